// file: shared/uef_pkg.sv
package uef_pkg;
  // ***********************************************************************
  // register map (byte offsets on the AXI4-Lite bus)
  // ***********************************************************************
  localparam logic [7:0] OFS_IEN = 8'h00;
  localparam logic [7:0] OFS_IST = 8'h04;
  localparam logic [7:0] OFS_FCT = 8'h08;
  localparam logic [7:0] OFS_MCT = 8'h0C;
  localparam logic [7:0] OFS_EFC = 8'h10;
  localparam logic [7:0] OFS_RC1 = 8'h14;
  localparam logic [7:0] OFS_RC2 = 8'h18;
  localparam logic [7:0] OFS_SC1 = 8'h1C;
  localparam logic [7:0] OFS_SC2 = 8'h20;
  localparam logic [7:0] OFS_LCT = 8'h24;
  localparam logic [7:0] OFS_LST = 8'h28;
  localparam logic [7:0] OFS_MST = 8'h2C;
  localparam logic [7:0] OFS_SPR = 8'h30;
  localparam logic [7:0] OFS_EMS = 8'h34;
  localparam logic [7:0] OFS_LVL = 8'h38;
  localparam logic [7:0] OFS_TRG = 8'h3C;
  localparam logic [7:0] OFS_EVS = 8'h40;
  localparam logic [7:0] OFS_EVM = 8'h44;
  // ***********************************************************************
  // reset values
  // ***********************************************************************
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_IST = 8'h01;
  localparam logic [7:0] RST_LST = 8'h60;
  localparam logic [7:0] RST_SPR = 8'hFF;
  // ***********************************************************************
  // field positions and masks
  // ***********************************************************************
  localparam logic [7:0] GATE_IEN = 8'hF0;
  localparam logic [7:0] GATE_IST = 8'h30;
  localparam logic [7:0] GATE_FCT = 8'h30;
  localparam logic [7:0] GATE_MCT = 8'hE0;
  localparam int EFC_GATE = 4;
  localparam int EFC_SPEC = 5;
  localparam int EFC_ARTS = 6;
  localparam int EFC_ACTS = 7;
  localparam int IEN_SPEC = 5;
  localparam int IST_SPEC = 4;
  localparam int MCT_RTS = 1;
  localparam logic [1:0] RXCMP_PAIR1 = 2'b10;
  localparam logic [1:0] RXCMP_PAIR2 = 2'b01;
  // event status bits: 0 special char, 1 stop-flow, 2 rx trigger
  localparam int EV_SPEC = 0;
  localparam int EV_STOP = 1;
  localparam int EV_TRIG = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } uef_char_t;

  typedef struct packed {
    logic [7:0] fill;
    logic [7:0] upper;
    logic [7:0] lower;
  } uef_level_t;
endpackage

// file: rtl/uef_flow.sv
`timescale 1ns/1ps
module uef_flow (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire uef_pkg::uef_char_t rx_char_i,
  input wire uef_pkg::uef_level_t rx_level_i,
  output uef_pkg::uef_char_t fifo_push_o,
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic ri_n_i,
  input wire logic cd_n_i,
  output logic tx_allow_o,
  output logic serial_out_o,
  output logic rts_n_o,
  output logic dtr_n_o,
  output logic general_output_two_n_o,
  output logic receive_ready_n_o,
  output logic transmit_ready_n_o,
  output logic irq_o,
  output logic irq_oe_o
);
  // ***********************************************************************
  // register storage
  // ***********************************************************************
  logic [7:0] interrupt_enable_reg;
  logic [7:0] interrupt_status_reg;
  logic [7:0] fifo_control_reg;
  logic [7:0] modem_control_reg;
  logic [7:0] enhanced_feature_control;
  logic [7:0] resume_char_one;
  logic [7:0] resume_char_two;
  logic [7:0] stop_char_one;
  logic [7:0] stop_char_two;
  logic [7:0] line_control_reg;
  logic [7:0] scratchpad_reg;
  logic [7:0] enhanced_mode_select_reg;
  logic [7:0] trigger_reg;
  logic [2:0] ev_status;
  logic [2:0] ev_mask;
  logic [3:0] mst_delta;
  logic rts_auto_hi;
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic wr_hit;
  logic spec_on, spec_match, spec_drop, stop_match, trig_hit;

  // gated merge: bits under mask only change while the gate is open
  function automatic logic [7:0] gated(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] gmask, input logic open);
    logic [7:0] keep;
    keep = open ? 8'h00 : gmask;
    gated = (old_v & keep) | (new_v & ~keep);
  endfunction

  // ***********************************************************************
  // AXI4-Lite write path
  // ***********************************************************************
  // address and data are latched independently so either may arrive first
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wbyte = w_data[7:0];

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= uef_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? uef_pkg::RESP_OKAY : uef_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // writable decode; read-only addresses answer with an error on write
  always_comb begin
    case (aw_addr)
      uef_pkg::OFS_IEN, uef_pkg::OFS_IST, uef_pkg::OFS_FCT, uef_pkg::OFS_MCT,
      uef_pkg::OFS_EFC, uef_pkg::OFS_RC1, uef_pkg::OFS_RC2, uef_pkg::OFS_SC1,
      uef_pkg::OFS_SC2, uef_pkg::OFS_LCT, uef_pkg::OFS_SPR, uef_pkg::OFS_EMS,
      uef_pkg::OFS_TRG, uef_pkg::OFS_EVS, uef_pkg::OFS_EVM: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // ***********************************************************************
  // gated enhanced registers
  // ***********************************************************************
  logic wr_lane;
  logic gate_open;
  assign wr_lane = do_write && w_strb[0];
  assign gate_open = enhanced_feature_control[uef_pkg::EFC_GATE];

  // enable, fifo and modem control: enhanced bits follow the gate
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      interrupt_enable_reg <= uef_pkg::RST_ZERO;
      fifo_control_reg <= uef_pkg::RST_ZERO;
      modem_control_reg <= uef_pkg::RST_ZERO;
    end else if (wr_lane) begin
      case (aw_addr)
        uef_pkg::OFS_IEN: interrupt_enable_reg <= gated(interrupt_enable_reg, wbyte,
          uef_pkg::GATE_IEN, gate_open);
        uef_pkg::OFS_FCT: fifo_control_reg <= gated(fifo_control_reg, wbyte,
          uef_pkg::GATE_FCT, gate_open);
        uef_pkg::OFS_MCT: modem_control_reg <= gated(modem_control_reg, wbyte,
          uef_pkg::GATE_MCT, gate_open);
        default: ;
      endcase
    end
  end

  // interrupt status: special bit set by detection wins over a write
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      interrupt_status_reg <= uef_pkg::RST_IST;
    end else begin
      if (wr_lane && aw_addr == uef_pkg::OFS_IST) begin
        interrupt_status_reg <= gated(interrupt_status_reg, wbyte,
          uef_pkg::GATE_IST, gate_open);
      end
      if (spec_match) begin
        interrupt_status_reg[uef_pkg::IST_SPEC] <= 1'b1;
      end
    end
  end

  // ***********************************************************************
  // plain registers and flow characters
  // ***********************************************************************
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      enhanced_feature_control <= uef_pkg::RST_ZERO;
      resume_char_one <= uef_pkg::RST_ZERO;
      resume_char_two <= uef_pkg::RST_ZERO;
      stop_char_one <= uef_pkg::RST_ZERO;
      stop_char_two <= uef_pkg::RST_ZERO;
      line_control_reg <= uef_pkg::RST_ZERO;
      scratchpad_reg <= uef_pkg::RST_SPR;
      enhanced_mode_select_reg <= uef_pkg::RST_ZERO;
      trigger_reg <= uef_pkg::RST_ZERO;
      ev_mask <= 3'b000;
    end else if (wr_lane) begin
      case (aw_addr)
        uef_pkg::OFS_EFC: enhanced_feature_control <= wbyte;
        uef_pkg::OFS_RC1: resume_char_one <= wbyte;
        uef_pkg::OFS_RC2: resume_char_two <= wbyte;
        uef_pkg::OFS_SC1: stop_char_one <= wbyte;
        uef_pkg::OFS_SC2: stop_char_two <= wbyte;
        uef_pkg::OFS_LCT: line_control_reg <= wbyte;
        uef_pkg::OFS_SPR: scratchpad_reg <= wbyte;
        uef_pkg::OFS_EMS: enhanced_mode_select_reg <= wbyte;
        uef_pkg::OFS_TRG: trigger_reg <= wbyte;
        uef_pkg::OFS_EVM: ev_mask <= wbyte[2:0];
        default: ;
      endcase
    end
  end

  // ***********************************************************************
  // special character and stop-flow detection
  // ***********************************************************************
  // bit 0 of the register meets bit 0 of the character, no reordering
  assign spec_on = enhanced_feature_control[uef_pkg::EFC_SPEC];
  assign spec_match = spec_on && rx_char_i.valid && rx_char_i.data == stop_char_two;
  // pair-two compare swallows the match; pair-one keeps it in the stream
  assign spec_drop = spec_match &&
    enhanced_feature_control[1:0] == uef_pkg::RXCMP_PAIR2;
  assign stop_match = rx_char_i.valid && (
    (enhanced_feature_control[1:0] == uef_pkg::RXCMP_PAIR1 && rx_char_i.data == stop_char_one) ||
    (enhanced_feature_control[1:0] == uef_pkg::RXCMP_PAIR2 &&
     rx_char_i.data == stop_char_two));
  assign trig_hit = rx_level_i.fill == trigger_reg && trigger_reg != 8'h00;

  // registered push toward the receive fifo
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fifo_push_o <= '0;
    end else begin
      fifo_push_o.valid <= rx_char_i.valid && !spec_drop;
      fifo_push_o.data <= rx_char_i.data;
    end
  end

  // sticky events: a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ev_status <= 3'b000;
    end else begin
      logic [2:0] set_v;
      logic [2:0] clr_v;
      set_v = '0;
      clr_v = '0;
      set_v[uef_pkg::EV_SPEC] = spec_match && interrupt_enable_reg[uef_pkg::IEN_SPEC];
      set_v[uef_pkg::EV_STOP] = stop_match;
      set_v[uef_pkg::EV_TRIG] = trig_hit && enhanced_feature_control[uef_pkg::EFC_ARTS];
      if (wr_lane && aw_addr == uef_pkg::OFS_EVS) begin
        clr_v = wbyte[2:0];
      end
      ev_status <= (ev_status & ~clr_v) | set_v;
    end
  end

  // ***********************************************************************
  // hardware flow control
  // ***********************************************************************
  // auto rts: high at upper level, low again below lower level
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rts_auto_hi <= 1'b0;
    end else if (!enhanced_feature_control[uef_pkg::EFC_ARTS]) begin
      rts_auto_hi <= 1'b0;
    end else if (rx_level_i.fill >= rx_level_i.upper) begin
      rts_auto_hi <= 1'b1;
    end else if (rx_level_i.fill < rx_level_i.lower) begin
      rts_auto_hi <= 1'b0;
    end
  end

  // pin drivers; auto control only overrides once software asserted rts
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
      general_output_two_n_o <= 1'b1;
      tx_allow_o <= 1'b1;
    end else begin
      if (enhanced_feature_control[uef_pkg::EFC_ARTS] && modem_control_reg[uef_pkg::MCT_RTS]) begin
        rts_n_o <= rts_auto_hi;
      end else begin
        rts_n_o <= !modem_control_reg[uef_pkg::MCT_RTS];
      end
      dtr_n_o <= !modem_control_reg[0];
      general_output_two_n_o <= !modem_control_reg[3];
      tx_allow_o <= !(enhanced_feature_control[uef_pkg::EFC_ACTS] && cts_n_i);
    end
  end

  // fixed-level pins of this slice
  assign serial_out_o = 1'b1;
  assign receive_ready_n_o = 1'b1;
  assign transmit_ready_n_o = 1'b0;
  // interrupt line floats while the output enable from modem control is off
  assign irq_o = |(ev_status & ev_mask);
  assign irq_oe_o = modem_control_reg[3];

  // modem delta bits: clear at reset, set on input change, cleared by read
  // the first cycle after reset only loads the history, so no false delta appears
  logic [3:0] mst_prev;
  logic mst_prev_ok;
  logic mst_rd;
  assign mst_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == uef_pkg::OFS_MST;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mst_delta <= 4'h0;
      mst_prev <= 4'h0;
      mst_prev_ok <= 1'b0;
    end else begin
      mst_prev <= {cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
      mst_prev_ok <= 1'b1;
      mst_delta <= (mst_rd ? 4'h0 : mst_delta) |
        ({4{mst_prev_ok}} & (mst_prev ^ {cd_n_i, ri_n_i, dsr_n_i, cts_n_i}));
    end
  end

  // ***********************************************************************
  // AXI4-Lite read path
  // ***********************************************************************
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      uef_pkg::OFS_IEN: rd_byte = interrupt_enable_reg;
      uef_pkg::OFS_IST: rd_byte = interrupt_status_reg;
      uef_pkg::OFS_FCT: rd_byte = fifo_control_reg;
      uef_pkg::OFS_MCT: rd_byte = modem_control_reg;
      uef_pkg::OFS_EFC: rd_byte = enhanced_feature_control;
      uef_pkg::OFS_RC1: rd_byte = resume_char_one;
      uef_pkg::OFS_RC2: rd_byte = resume_char_two;
      uef_pkg::OFS_SC1: rd_byte = stop_char_one;
      uef_pkg::OFS_SC2: rd_byte = stop_char_two;
      uef_pkg::OFS_LCT: rd_byte = line_control_reg;
      uef_pkg::OFS_LST: rd_byte = uef_pkg::RST_LST;
      uef_pkg::OFS_MST: rd_byte = {~cd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n_i, mst_delta};
      uef_pkg::OFS_SPR: rd_byte = scratchpad_reg;
      uef_pkg::OFS_EMS: rd_byte = enhanced_mode_select_reg;
      uef_pkg::OFS_LVL: rd_byte = rx_level_i.fill;
      uef_pkg::OFS_TRG: rd_byte = trigger_reg;
      uef_pkg::OFS_EVS: rd_byte = {5'b00000, ev_status};
      uef_pkg::OFS_EVM: rd_byte = {5'b00000, ev_mask};
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= uef_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_hit ? uef_pkg::RESP_OKAY : uef_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ***********************************************************************
  // checks
  // ***********************************************************************
  AST_GATE_HOLD: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !gate_open |=> (interrupt_enable_reg & uef_pkg::GATE_IEN) ==
    ($past(interrupt_enable_reg) & uef_pkg::GATE_IEN)) else $error("gated bits moved");
  AST_GATE_WRITE: assert property (@(posedge clock_i) disable iff (!rstn_i)
    wr_lane && gate_open && aw_addr == uef_pkg::OFS_MCT |=>
    modem_control_reg == $past(wbyte)) else $error("open gate write lost");
  AST_SPEC_IST: assert property (@(posedge clock_i) disable iff (!rstn_i)
    spec_match |=> interrupt_status_reg[uef_pkg::IST_SPEC]) else $error("special not flagged");
  AST_SPEC_DROP: assert property (@(posedge clock_i) disable iff (!rstn_i)
    spec_drop |=> !fifo_push_o.valid && ev_status[uef_pkg::EV_STOP]) else $error("drop failed");
  AST_PAIR1_KEEP: assert property (@(posedge clock_i) disable iff (!rstn_i)
    spec_match && enhanced_feature_control[1:0] == uef_pkg::RXCMP_PAIR1 |=>
    fifo_push_o.valid) else $error("pair one char lost");
  AST_RTS_UP: assert property (@(posedge clock_i) disable iff (!rstn_i)
    enhanced_feature_control[uef_pkg::EFC_ARTS] && modem_control_reg[uef_pkg::MCT_RTS] &&
    rx_level_i.fill >= rx_level_i.upper ##1 $stable(enhanced_feature_control) &&
    $stable(modem_control_reg) |=> rts_n_o) else $error("rts not raised");
  AST_RTS_PLAIN: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !enhanced_feature_control[uef_pkg::EFC_ARTS] |=>
    rts_n_o == !$past(modem_control_reg[uef_pkg::MCT_RTS])) else $error("rts not plain");
  AST_CTS_STOP: assert property (@(posedge clock_i) disable iff (!rstn_i)
    enhanced_feature_control[uef_pkg::EFC_ACTS] && cts_n_i |=> !tx_allow_o)
    else $error("tx not stopped");
  // a stop match must survive a write-one clear in the same cycle
  AST_STOP_SET: assert property (@(posedge clock_i) disable iff (!rstn_i)
    stop_match |=> ev_status[uef_pkg::EV_STOP]) else $error("stop event lost");
  COV_SPEC: cover property (@(posedge clock_i) disable iff (!rstn_i) spec_match);
  COV_DROP: cover property (@(posedge clock_i) disable iff (!rstn_i) spec_drop);
  COV_RTS: cover property (@(posedge clock_i) disable iff (!rstn_i) $rose(rts_auto_hi));
  COV_CTS: cover property (@(posedge clock_i) disable iff (!rstn_i) $fell(tx_allow_o));
endmodule

// file: test/uef_remote.sv
`timescale 1ns/1ps
// ****
// remote serial party
// ****
module uef_remote (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [7:0] byte_i,
  input wire logic go_i,
  input wire logic hold_i,
  output uef_pkg::uef_char_t char_o,
  output logic cts_n_o
);
  // one-cycle strobe; idle data flips so a stale byte never looks fresh
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      char_o <= '0;
    end else begin
      char_o.valid <= go_i;
      char_o.data <= go_i ? byte_i : ~char_o.data;
    end
  end
  // high while the remote cannot take data
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cts_n_o <= 1'b0;
    end else begin
      cts_n_o <= hold_i;
    end
  end
endmodule

// file: test/tb_top.sv
`timescale 1ns/1ps
// ****
// bench
// ****
module tb_top;
  logic clock_i = 0;
  logic rstn_i = 0;
  logic [7:0] awa = 0, ara = 0, pb = 0, got;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, go = 0, hold = 0, hit;
  logic [31:0] wd = 0, rdat;
  logic awr, wrd, bv, arr, rv, cts_n, txa, so, rts_n, dtr_n, op2_n, rr_n, tr_n, irq, ioe;
  logic [1:0] brs, rrs, resp;
  uef_pkg::uef_char_t rxc, push;
  uef_pkg::uef_level_t lvl = '0;
  int mismatches = 0, n_tests = 0, i;
  // addr and expected value; the last four are written first
  logic [15:0] rows [19] = '{16'h0000, 16'h0401, 16'h0800, 16'h0C00, 16'h1000, 16'h1400,
    16'h1800, 16'h1C00, 16'h2000, 16'h2400, 16'h2860, 16'h2C10, 16'h30FF, 16'h3400,
    16'h3800, 16'h14A5, 16'h185A, 16'h1C3C, 16'h20C3};
  always #10 clock_i = ~clock_i;
  uef_remote uef_remote_inst (.clock_i, .rstn_i, .byte_i(pb), .go_i(go), .hold_i(hold),
    .char_o(rxc), .cts_n_o(cts_n));
  uef_flow uef_flow_inst (.clock_i, .rstn_i, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rry), .rx_char_i(rxc),
    .rx_level_i(lvl), .fifo_push_o(push), .cts_n_i(cts_n), .dsr_n_i(1'b1), .ri_n_i(1'b1),
    .cd_n_i(1'b1), .tx_allow_o(txa), .serial_out_o(so), .rts_n_o(rts_n), .dtr_n_o(dtr_n),
    .general_output_two_n_o(op2_n), .receive_ready_n_o(rr_n),
    .transmit_ready_n_o(tr_n), .irq_o(irq), .irq_oe_o(ioe));
  task automatic tally_and_finish;
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask
  // write: address and data offered together, each released once taken
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, tb, dn;
    dn = 0;
    @(posedge clock_i);
    awa <= a;
    wd <= {24'h00_0000, d};
    awv <= 1;
    wv <= 1;
    bry <= 1;
    for (int k = 0; !dn; k++) begin
      if (k > 40) begin
        mismatches++;
        tally_and_finish();
      end
      @(negedge clock_i);
      ta = awv & awr;
      tw = wv & wrd;
      tb = bv & bry;
      @(posedge clock_i);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      if (tb) begin
        bry <= 0;
        resp = brs;
        dn = 1;
      end
    end
    @(negedge clock_i);
  endtask
  task automatic axr(input logic [7:0] a);
    logic ta, tr, dn;
    dn = 0;
    @(posedge clock_i);
    ara <= a;
    arv <= 1;
    rry <= 1;
    for (int k = 0; !dn; k++) begin
      if (k > 40) begin
        mismatches++;
        tally_and_finish();
      end
      @(negedge clock_i);
      ta = arv & arr;
      tr = rv & rry;
      @(posedge clock_i);
      if (ta) arv <= 0;
      if (tr) begin
        rry <= 0;
        got = rdat[7:0];
        resp = rrs;
        dn = 1;
      end
    end
  endtask
  // one character from the remote; push seen within four cycles
  task automatic send(input logic [7:0] b);
    @(posedge clock_i);
    pb <= b;
    go <= 1;
    @(posedge clock_i);
    go <= 0;
    hit = 0;
    repeat (4) begin
      @(negedge clock_i);
      if (push.valid === 1'b1) begin
        hit = 1;
        got = push.data;
      end
    end
  endtask
  task automatic lv(input logic [7:0] f, input logic [7:0] e);
    @(posedge clock_i);
    lvl.fill <= f;
    repeat (3) @(negedge clock_i);
    chk(e, {7'h00, rts_n});
  endtask
  initial begin
    lvl.upper = 8'h08;
    lvl.lower = 8'h04;
    repeat (3) @(negedge clock_i);
    chk(8'hF9, {rts_n, dtr_n, op2_n, so, rr_n, tr_n, ioe, txa});
    chk(8'h00, {7'h00, irq});
    repeat (2) @(posedge clock_i);
    rstn_i <= 1;
    // register table: reset values, then flow characters read back
    for (i = 0; i < 19; i++) begin
      if (i > 14) axw(rows[i][15:8], rows[i][7:0]);
      axr(rows[i][15:8]);
      chk(rows[i][7:0], got);
    end
    axw(uef_pkg::OFS_LST, 8'h11);
    chk({6'h00, uef_pkg::RESP_SLVERR}, {6'h00, resp});
    axr(8'h80);
    chk({6'h00, uef_pkg::RESP_SLVERR}, {6'h00, resp});
    // gate: closed, opened, closed again
    axw(uef_pkg::OFS_IEN, 8'hF3);
    axr(uef_pkg::OFS_IEN);
    chk(8'h03, got);
    axw(uef_pkg::OFS_EFC, 8'h10);
    axw(uef_pkg::OFS_IEN, 8'hF3);
    axr(uef_pkg::OFS_IEN);
    chk(8'hF3, got);
    axw(uef_pkg::OFS_EFC, 8'h00);
    axw(uef_pkg::OFS_IEN, 8'h20);
    axr(uef_pkg::OFS_IEN);
    chk(8'hF0, got);
    // special detect with pair-one compare; a non-match still goes to the fifo
    axw(uef_pkg::OFS_EFC, 8'h32);
    axw(uef_pkg::OFS_SC2, 8'h01);
    send(8'h80);
    chk(8'h01, {7'h00, hit});
    chk(8'h80, got);
    axr(uef_pkg::OFS_IST);
    chk(8'h00, got & 8'h10);
    send(8'h01);
    chk(8'h01, {7'h00, hit});
    chk(8'h01, got);
    axr(uef_pkg::OFS_IST);
    chk(8'h10, got & 8'h10);
    // pair-two compare swallows the match; mask then clear
    axw(uef_pkg::OFS_EFC, 8'h10);
    axw(uef_pkg::OFS_EFC, 8'h31);
    axw(uef_pkg::OFS_EVS, 8'hFF);
    send(8'h01);
    chk(8'h00, {7'h00, hit});
    chk(8'h00, {7'h00, irq});
    axr(uef_pkg::OFS_EVS);
    chk(8'h03, got);
    axw(uef_pkg::OFS_EVM, 8'h07);
    chk(8'h01, {7'h00, irq});
    axw(uef_pkg::OFS_EVS, 8'h03);
    chk(8'h00, {7'h00, irq});
    // rts as plain output, then automatic with hysteresis
    axw(uef_pkg::OFS_EFC, 8'h10);
    axw(uef_pkg::OFS_MCT, 8'h02);
    chk(8'h00, {7'h00, rts_n});
    axw(uef_pkg::OFS_MCT, 8'h00);
    chk(8'h01, {7'h00, rts_n});
    axw(uef_pkg::OFS_MCT, 8'h09);
    chk(8'h09, {4'h0, rts_n, dtr_n, op2_n, ioe});
    axw(uef_pkg::OFS_TRG, 8'h08);
    axw(uef_pkg::OFS_EFC, 8'h50);
    lv(8'h02, 8'h01);
    axw(uef_pkg::OFS_MCT, 8'h02);
    lv(8'h02, 8'h00);
    lv(8'h08, 8'h01);
    chk(8'h01, {7'h00, irq});
    lv(8'h05, 8'h01);
    lv(8'h03, 8'h00);
    // automatic cts pauses and resumes the sender
    axw(uef_pkg::OFS_EFC, 8'h10);
    axw(uef_pkg::OFS_EFC, 8'h90);
    @(posedge clock_i);
    hold <= 1;
    repeat (3) @(negedge clock_i);
    chk(8'h00, {7'h00, txa});
    @(posedge clock_i);
    hold <= 0;
    repeat (3) @(negedge clock_i);
    chk(8'h01, {7'h00, txa});
    // second reset in mid-run clears the enhanced state
    @(posedge clock_i);
    rstn_i <= 0;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1;
    axr(uef_pkg::OFS_IEN);
    chk(8'h00, got);
    axr(uef_pkg::OFS_EFC);
    chk(8'h00, got);
    tally_and_finish();
  end
endmodule
